// file: logic/acm_map.vh
`ifndef ACM_MAP_VH
`define ACM_MAP_VH
// Register byte offsets
`define ACM_OFS_POWER 12'h004
`define ACM_OFS_CONT 12'h008
`define ACM_OFS_BUSY 12'h00C
`define ACM_OFS_MODE 12'h0D4
`define ACM_OFS_IRQ_STAT 12'h0E0
`define ACM_OFS_IRQ_EN 12'h0E4
`define ACM_OFS_IRQ_CLR 12'h0E8
// Field positions
`define ACM_BIT_SOFT_START 0
`define ACM_BIT_OPERATE 1
`define ACM_BIT_CONT 0
`define ACM_BIT_CONV_EN 7
`define ACM_BIT_BUSY_ANY 0
`define ACM_BIT_BUSY_SOFT 1
`define ACM_MODE_WMASK 32'h0000FFFF
`define ACM_RES_LSB 10
`define ACM_RES_10BIT 2'h0
`define ACM_RES_12BIT 2'h1
`define ACM_BIT_ANALOG_STOP 8
`define ACM_IRQ_DONE 0
`define ACM_IRQ_SOFT_DONE 1
// Reset values
`define ACM_RST_MODE 32'h00000558
// Timing: conversion lengths in pclk cycles
`define ACM_CYC_12BIT 16'h004A
`define ACM_CYC_10BIT 16'h0044
`endif

// file: logic/acm_sync2.v
`timescale 1ns/10ps
// Two-stage synchroniser for a level from outside the clock domain
module acm_sync2 (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Data
    input wire d_in,
    output wire q_out
);
    reg s1_reg;
    reg s2_reg;

    // First stage feeds only the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
        end
    end

    assign q_out = s2_reg;
endmodule // acm_sync2

// file: logic/acm_conv_timer.v
`timescale 1ns/10ps
// Counts the length of one conversion; done pulses in the cycle after the last busy cycle
module acm_conv_timer #(
    parameter CW = 16
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire start,
    input wire abort,
    input wire [CW-1:0] length,
    // Status
    output reg busy,
    output reg done
);
    reg [CW-1:0] cnt_reg;

    // Load on start, count down, flag the end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {CW{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start && !busy) begin
                busy <= 1'b1;
                cnt_reg <= length;
            end else if (busy) begin
                if (cnt_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // acm_conv_timer

// file: logic/acm_top.v
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "acm_map.vh"

module acm_top (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Timer unit trigger, asynchronous level pulse
    input wire timer_unit_trig,
    // Converter status and control
    output reg conv_active,
    output reg [1:0] res_sel,
    output reg irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;

    reg operate_reg;
    reg conv_en_reg;
    reg cont_reg;
    reg [31:0] mode_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_en_reg;
    reg soft_pend_reg;
    reg soft_busy_reg;
    reg [1:0] state_reg;
    reg trig_d_reg;
    reg start_pulse_reg;
    reg [1:0] state_next;
    reg start_next;
    reg soft_take;
    wire trig_sync;
    wire trig_rise;
    wire conv_done;
    wire wr_en;
    wire rd_en;
    wire soft_wr;
    wire analog_stop;
    wire run_ok;
    wire [15:0] conv_len;
    wire [1:0] irq_clr;
    wire wr_power;
    wire wr_cont;
    wire wr_mode;
    wire wr_irq_en;
    wire wr_irq_clr;
    wire conv_end;
    reg [31:0] prdata_next;

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes; a write lands at the edge where ready is sampled high
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite; // Read data is loaded during setup

    // Per-register write strobes, decoded once for all processes
    assign wr_power = wr_en && (paddr == `ACM_OFS_POWER);
    assign wr_cont = wr_en && (paddr == `ACM_OFS_CONT);
    assign wr_mode = wr_en && (paddr == `ACM_OFS_MODE);
    assign wr_irq_en = wr_en && (paddr == `ACM_OFS_IRQ_EN);
    assign wr_irq_clr = wr_en && (paddr == `ACM_OFS_IRQ_CLR);
    assign soft_wr = wr_power && pwdata[`ACM_BIT_SOFT_START];
    assign irq_clr = wr_irq_clr ? pwdata[1:0] : 2'h0;

    // Run gating and conversion length
    assign analog_stop = mode_reg[`ACM_BIT_ANALOG_STOP];
    assign run_ok = operate_reg && !analog_stop;
    assign conv_len = (mode_reg[`ACM_RES_LSB+1:`ACM_RES_LSB] == `ACM_RES_12BIT) ?
        `ACM_CYC_12BIT : `ACM_CYC_10BIT;

    ////////////////////////////////////////////////////////////////////////////
    // Timer trigger synchroniser and edge detect
    acm_sync2 u_trig_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_in(timer_unit_trig),
        .q_out(trig_sync)
    );

    assign trig_rise = trig_sync && !trig_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion length timer
    acm_conv_timer #(
        .CW(16)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_pulse_reg),
        .abort(!run_ok),
        .length(conv_len),
        .busy(),
        .done(conv_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Start arbitration: software, timer or continuous
    always @* begin
        state_next = state_reg;
        start_next = 1'b0;
        soft_take = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (run_ok && (soft_pend_reg || trig_rise ||
                    (conv_en_reg && cont_reg))) begin
                    start_next = 1'b1;
                    soft_take = soft_pend_reg;
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (!run_ok || conv_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register and the one-cycle start pulse to the timer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            start_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_pulse_reg <= start_next;
        end
    end

    // General busy flag, high from the start to the end of a conversion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_active <= 1'b0;
        end else begin
            conv_active <= (state_next == ST_CONV);
        end
    end

    // Last trigger level, for the rising-edge detector
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_d_reg <= 1'b0;
        end else begin
            trig_d_reg <= trig_sync;
        end
    end

    // Pending software request; a new write wins over the take
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_pend_reg <= 1'b0;
        end else if (soft_wr && run_ok) begin
            soft_pend_reg <= 1'b1;
        end else if (soft_take || !run_ok) begin
            soft_pend_reg <= 1'b0;
        end
    end

    // A conversion ends when the machine leaves the converting state
    assign conv_end = (state_reg == ST_CONV) && (state_next == ST_IDLE);

    // Software busy at real start, cleared at end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_busy_reg <= 1'b0;
        end else if (soft_take) begin
            soft_busy_reg <= 1'b1;
        end else if (conv_end) begin
            soft_busy_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operate bit; the soft-start bit beside it is a pulse and not stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operate_reg <= 1'b0;
        end else if (wr_power) begin
            operate_reg <= pwdata[`ACM_BIT_OPERATE];
        end
    end

    // Conversion enable and continuous bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_en_reg <= 1'b0;
            cont_reg <= 1'b0;
        end else if (wr_cont) begin
            conv_en_reg <= pwdata[`ACM_BIT_CONV_EN];
            cont_reg <= pwdata[`ACM_BIT_CONT];
        end
    end

    // Mode register; only the lower half holds bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `ACM_RST_MODE;
        end else if (wr_mode) begin
            mode_reg <= pwdata & `ACM_MODE_WMASK;
        end
    end

    // Interrupt enable mask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 2'h0;
        end else if (wr_irq_en) begin
            irq_en_reg <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, set wins over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg[`ACM_IRQ_DONE] <= conv_done ||
                (irq_stat_reg[`ACM_IRQ_DONE] && !irq_clr[`ACM_IRQ_DONE]);
            irq_stat_reg[`ACM_IRQ_SOFT_DONE] <= (conv_done && soft_busy_reg) ||
                (irq_stat_reg[`ACM_IRQ_SOFT_DONE] && !irq_clr[`ACM_IRQ_SOFT_DONE]);
        end
    end

    // Level interrupt, one cycle behind the status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Resolution select to the converter, taken from the mode register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_sel <= 2'h0;
        end else begin
            res_sel <= mode_reg[`ACM_RES_LSB+1:`ACM_RES_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection; unmapped offsets and write-only bits read as 0
    always @* begin
        prdata_next = 32'h00000000;
        if (paddr == `ACM_OFS_POWER) begin
            prdata_next = {30'h0, operate_reg, 1'b0};
        end else if (paddr == `ACM_OFS_CONT) begin
            prdata_next = {24'h0, conv_en_reg, 6'h0, cont_reg};
        end else if (paddr == `ACM_OFS_BUSY) begin
            prdata_next = {30'h0, soft_busy_reg, conv_active};
        end else if (paddr == `ACM_OFS_MODE) begin
            prdata_next = mode_reg;
        end else if (paddr == `ACM_OFS_IRQ_STAT) begin
            prdata_next = {30'h0, irq_stat_reg};
        end else if (paddr == `ACM_OFS_IRQ_EN) begin
            prdata_next = {30'h0, irq_en_reg};
        end
    end

    // Ready answers the setup cycle, so the access phase has no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    // Read data captured in the setup cycle, held until the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= prdata_next;
        end
    end
endmodule // acm_top

// file: dv/acm_monitor.sv
`timescale 1ns/10ps
`include "acm_map.vh"
module acm_monitor (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Converter
    input wire timer_unit_trig,
    input wire conv_active,
    input wire [1:0] res_sel,
    input wire irq
);
    wire wr = psel && penable && pready && pwrite;
    reg op_reg;
    reg stop_reg;
    reg [1:0] res_reg;
    // Shadow copies of the gating and resolution fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= 1'h0;
            stop_reg <= 1'h1;
            res_reg <= 2'h1;
        end else if (wr && paddr == `ACM_OFS_POWER) begin
            op_reg <= pwdata[1];
        end else if (wr && paddr == `ACM_OFS_MODE) begin
            stop_reg <= pwdata[8];
            res_reg <= pwdata[11:10];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    no_slverr_a: assert property (pready |-> !pslverr)
        else $error("error response");
    start_reads_zero_a: assert property (pready && !pwrite && paddr == `ACM_OFS_POWER
        |-> !prdata[0])
        else $error("start bit read back");
    start_gated_a: assert property ($rose(conv_active) |-> op_reg && !stop_reg)
        else $error("conversion while stopped");
    soft_start_a: assert property (wr && paddr == `ACM_OFS_POWER && pwdata[0] && op_reg
        && !stop_reg && !conv_active |-> ##[1:4] conv_active)
        else $error("soft start ignored");
    trig_start_a: assert property ($rose(timer_unit_trig) && op_reg && !stop_reg
        && !conv_active |-> ##[1:6] conv_active)
        else $error("trigger ignored");
    busy_hold_a: assert property ($rose(conv_active) |-> conv_active [*8])
        else $error("busy too short");
    res_follow_a: assert property (wr && paddr == `ACM_OFS_MODE
        |=> ##[0:1] res_sel == res_reg)
        else $error("resolution not applied");
endmodule // acm_monitor
bind acm_top acm_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .timer_unit_trig(timer_unit_trig), .conv_active(conv_active), .res_sel(res_sel));

// file: dv/acm_tb.sv
`timescale 1ns/10ps
`include "acm_map.vh"
module testbench;
    reg pclk = 1'h0;
    reg presetn = 1'h0;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg trig = 1'h0;
    wire [31:0] prdata;
    wire pready, pslverr, conv_active, irq;
    wire [1:0] res_sel;
    reg [31:0] rd;
    integer bad_count = 0;
    integer tests_run = 0;
    integer len;
    // Clock
    always #25 pclk = ~pclk;
    acm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_unit_trig(trig),
        .conv_active(conv_active), .res_sel(res_sel), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One APB transfer, held until ready is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            while (pready !== 1'h1) @(posedge pclk);
            rd = prdata;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk); // Idle cycle before the next setup
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        begin
            apb(1'h0, a, 32'h0);
            chk("read", rd, e);
        end
    endtask
    // Bounded wait for a start, then length of the conversion
    task rise;
        begin
            len = 0;
            while (conv_active !== 1'h1 && len < 8) begin
                @(posedge pclk);
                len = len + 1;
            end
        end
    endtask
    task meas;
        begin
            len = 0;
            while (conv_active === 1'h1 && len < 200) begin
                @(posedge pclk);
                len = len + 1;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Start refused while stopped or held in analog stop
    task t_gate;
        begin
            apb(1'h1, `ACM_OFS_POWER, 32'h1);
            rise;
            chk("off", conv_active, 1'h0);
            apb(1'h1, `ACM_OFS_MODE, 32'h560);
            apb(1'h1, `ACM_OFS_POWER, 32'h2);
            apb(1'h1, `ACM_OFS_POWER, 32'h3);
            rise;
            chk("astop", conv_active, 1'h0);
        end
    endtask
    // Software conversion, busy flags, length and interrupt
    task t_soft(input [31:0] mode, input integer clen);
        begin
            apb(1'h1, `ACM_OFS_MODE, mode);
            @(posedge pclk);
            chk("res", res_sel, mode[11:10]);
            apb(1'h1, `ACM_OFS_POWER, 32'h2);
            rise;
            chk("zero", conv_active, 1'h0);
            apb(1'h1, `ACM_OFS_POWER, 32'h3);
            rise;
            rdc(`ACM_OFS_BUSY, 32'h3);
            rdc(`ACM_OFS_POWER, 32'h2);
            meas;
            // Six edges pass between the first high sample and the count
            chk("len", len + 6 >= clen && len + 6 <= clen + 3, 1'h1);
            repeat (3) @(posedge pclk);
            rdc(`ACM_OFS_BUSY, 32'h0);
            rdc(`ACM_OFS_IRQ_STAT, 32'h3);
            chk("irq", irq, 1'h1);
            apb(1'h1, `ACM_OFS_IRQ_CLR, 32'h3);
            repeat (2) @(posedge pclk);
            chk("irqclr", irq, 1'h0);
        end
    endtask
    // Timer trigger, masked interrupt
    task t_timer;
        begin
            apb(1'h1, `ACM_OFS_IRQ_EN, 32'h2);
            trig <= 1'h1;
            repeat (3) @(posedge pclk);
            trig <= 1'h0;
            rise;
            rdc(`ACM_OFS_BUSY, 32'h1);
            meas;
            repeat (3) @(posedge pclk);
            rdc(`ACM_OFS_IRQ_STAT, 32'h1);
            chk("mask", irq, 1'h0);
            apb(1'h1, `ACM_OFS_IRQ_CLR, 32'h3);
        end
    endtask
    // Continuous conversion needs the enable bit
    task t_cont;
        begin
            apb(1'h1, `ACM_OFS_CONT, 32'h1);
            rise;
            chk("noen", conv_active, 1'h0);
            rdc(`ACM_OFS_CONT, 32'h1);
            apb(1'h1, `ACM_OFS_CONT, 32'h81);
            rise;
            chk("cont", conv_active, 1'h1);
            meas;
            rise;
            chk("again", conv_active, 1'h1);
            apb(1'h1, `ACM_OFS_CONT, 32'h0);
            meas;
            rise;
            chk("stopped", conv_active, 1'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task test_done;
        begin
            $display("Checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #500000;
        bad_count = bad_count + 1;
        test_done;
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdc(`ACM_OFS_POWER, 32'h0);
        rdc(`ACM_OFS_CONT, 32'h0);
        rdc(`ACM_OFS_BUSY, 32'h0);
        rdc(`ACM_OFS_MODE, `ACM_RST_MODE);
        rdc(12'h0F0, 32'h0);
        apb(1'h1, `ACM_OFS_IRQ_EN, 32'h3);
        t_gate;
        t_soft(32'h460, 74);
        t_soft(32'h060, 68);
        t_timer;
        t_cont;
        test_done;
    end
endmodule // testbench
